// File: logic/eag_defs.svh
// constants of the effective address generator
// assumes inclusion by bare name from the package and the design modules
// Summary of operation
// - eighteen addressing modes in nine basic groups
// - direct modes pick one of eight data/address registers
// - address indirect: plain, postinc, predec, d16, indexed
// - short displacements sign-extended to 32 bits, added
// - index word or long, scaled by 1/2/4/8
// - optional base displacement added to base register
// - outer displacement added after the indirect fetch
// - indirection reads long word as next pointer
// - postindex after fetch, preindex before fetch
// - pc-relative forms use pc as base
// - absolute short or long address from extension
// - immediate operand of 8, 16 or 32 bits
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH

// index select: bit 3 picks the address register bank
`define EAG_IDX_AREG_BIT 3
// index scale codes: shift amount
`define EAG_SCALE_ONE 2'h0
// default index width when omitted: word
`define EAG_IDX_LONG_DFLT 1'h0
// reset values of registered outputs
`define EAG_RST_WORD 32'h00000000
`define EAG_RST_REGNUM 3'h0

`endif

// File: logic/eag_idx_if.sv
// carrier between the core sequencer and the index scaler
// assumes both ends run combinationally in one clock domain
`timescale 1ns/1ps
`default_nettype none

interface eag_idx_if;
    logic [31:0] idx_raw; // selected index register value
    logic idx_long; // use full long word
    logic [1:0] idx_scale; // shift amount 0..3
    logic [31:0] idx_scaled; // scaled index term
    modport core (output idx_raw, output idx_long, output idx_scale, input idx_scaled);
    modport unit (input idx_raw, input idx_long, input idx_scale, output idx_scaled);
endinterface

`default_nettype wire

// File: logic/eag_index_scaler.sv
// index scaler: word or long index, times one, two, four or eight
// assumes inputs are stable within the cycle; purely combinational
`timescale 1ns/1ps
`default_nettype none

module eag_index_scaler (
    eag_idx_if.unit idx
);
    import eag_pkg::*;

    logic [31:0] idx_ext; // sign-extended or full index

    // word index is sign extended, long index used as is
    always_comb begin
        idx_ext = idx.idx_long ? idx.idx_raw : eag_sext(idx.idx_raw, EAG_W_16);
        idx.idx_scaled = idx_ext << idx.idx_scale;
    end
endmodule // eag_index_scaler

`default_nettype wire

// File: logic/eag_pkg.sv
// types shared by the effective address generator modules
// assumes the constants header sits in the same folder
`include "eag_defs.svh"

package eag_pkg;

    // addressing modes, one code per mode
    typedef enum logic [4:0] {
        EAG_M_DREG = 5'h00, EAG_M_AREG = 5'h01, EAG_M_AIND = 5'h02,
        EAG_M_APOSTINC = 5'h03, EAG_M_APREDEC = 5'h04, EAG_M_ADISP = 5'h05,
        EAG_M_AIDX8 = 5'h06, EAG_M_AIDXBD = 5'h07, EAG_M_MIPOST = 5'h08,
        EAG_M_MIPRE = 5'h09, EAG_M_PCDISP = 5'h0A, EAG_M_PCIDX8 = 5'h0B,
        EAG_M_PCIDXBD = 5'h0C, EAG_M_PCMIPOST = 5'h0D, EAG_M_PCMIPRE = 5'h0E,
        EAG_M_ABSW = 5'h0F, EAG_M_ABSL = 5'h10, EAG_M_IMM = 5'h11
    } eag_mode_t;

    // width of a displacement or extension value
    typedef enum logic [1:0] {
        EAG_W_NONE = 2'h0, EAG_W_8 = 2'h1, EAG_W_16 = 2'h2, EAG_W_32 = 2'h3
    } eag_width_t;

    // operand size for postincrement and predecrement
    typedef enum logic [1:0] {
        EAG_S_BYTE = 2'h0, EAG_S_WORD = 2'h1, EAG_S_LONG = 2'h2
    } eag_size_t;

    // what the answer names
    typedef enum logic [1:0] {
        EAG_K_MEM = 2'h0, EAG_K_DREG = 2'h1, EAG_K_AREG = 2'h2, EAG_K_IMM = 2'h3
    } eag_kind_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        EAG_ST_IDLE = 3'h1, EAG_ST_FETCH = 3'h2, EAG_ST_DONE = 3'h4
    } eag_state_t;

    // sign extend a value of the given width; none gives zero
    function automatic logic [31:0] eag_sext(input logic [31:0] v, input eag_width_t w);
        logic [31:0] r;
        r = 32'h00000000;
        unique case (w)
            EAG_W_8: r = {{24{v[7]}}, v[7:0]};
            EAG_W_16: r = {{16{v[15]}}, v[15:0]};
            EAG_W_32: r = v;
            EAG_W_NONE: r = 32'h00000000;
        endcase
        return r;
    endfunction

    // operand size in bytes
    function automatic logic [31:0] eag_size_bytes(input eag_size_t s);
        logic [31:0] r;
        r = 32'h00000001;
        unique case (s)
            EAG_S_BYTE: r = 32'h00000001;
            EAG_S_WORD: r = 32'h00000002;
            EAG_S_LONG: r = 32'h00000004;
            default: r = 32'h00000001;
        endcase
        return r;
    endfunction

endpackage

// File: logic/eag_top.sv
// effective address generator: decoded mode fields to operand address
// assumes decode pipe and bus controller share ref_clk; no synchronisers needed
`timescale 1ns/1ps
`default_nettype none
`include "eag_defs.svh"

module eag_top (
    input wire logic ref_clk, // core clock
    input wire logic rst, // synchronous reset, active high
    input wire logic req_valid, // decoded request present
    output logic req_ready, // sequencer can take a request
    input wire eag_pkg::eag_mode_t req_mode, // addressing mode
    input wire logic [2:0] req_reg_num, // register number of the mode field
    input wire eag_pkg::eag_size_t req_op_size, // operand size
    input wire logic req_index_present, // an index term is used
    input wire logic [3:0] req_index_sel, // index register, bit 3 = address bank
    input wire logic req_index_fmt_given, // size and scale were written
    input wire logic req_index_long, // long index when given
    input wire logic [1:0] req_index_scale, // scale shift when given
    input wire logic [31:0] req_base_disp, // base or short displacement
    input wire eag_pkg::eag_width_t req_base_disp_width, // its width, none = absent
    input wire logic [31:0] req_outer_disp, // outer displacement
    input wire eag_pkg::eag_width_t req_outer_disp_width, // its width, none = absent
    input wire logic [31:0] req_ext_data, // absolute address or immediate
    input wire eag_pkg::eag_width_t req_ext_width, // immediate width
    input wire logic [31:0] req_pc, // program counter base
    input wire logic [7:0][31:0] data_regs, // data register file
    input wire logic [7:0][31:0] addr_regs, // address register file
    output logic ea_valid, // answer pulse
    output eag_pkg::eag_kind_t ea_kind, // memory, register or immediate
    output logic [31:0] ea_value, // address or immediate value
    output logic [2:0] ea_reg_num, // register for direct kinds
    output logic wb_valid, // base register update pulse
    output logic [2:0] wb_reg_num, // address register to update
    output logic [31:0] wb_value, // its new value
    output logic mem_req, // indirect pointer read request
    output logic [31:0] mem_addr, // long-word pointer address
    input wire logic mem_ack, // read data returned
    input wire logic [31:0] mem_rdata // returned pointer
);
    import eag_pkg::*;

    // sequencer and registered outputs
    eag_state_t state, next_state; // current and next step
    logic next_ea_valid; // answer pulse next
    eag_kind_t next_ea_kind; // answer kind next
    logic [31:0] next_ea_value; // answer value next
    logic [2:0] next_ea_reg_num; // direct register next
    logic next_wb_valid; // writeback pulse next
    logic [2:0] next_wb_reg_num; // writeback register next
    logic [31:0] next_wb_value; // writeback value next
    logic [31:0] next_mem_addr; // pointer address next
    logic [31:0] post_add, next_post_add; // term added after the fetch

    // decoded selections
    logic [2:0] data_reg_sel; // data register chosen by the mode field
    logic [2:0] addr_reg_sel; // address register chosen by the mode field
    logic [3:0] index_reg_sel; // index register chosen by the extension
    logic [31:0] base_val; // address register or pc base
    logic [31:0] base_disp; // sign-extended base displacement
    logic [31:0] outer_disp; // sign-extended outer displacement
    logic [31:0] idx_term; // scaled index, zero when absent
    logic [31:0] size_bytes; // operand size in bytes
    logic is_pc; // pc-relative mode
    logic take; // request taken this edge

    eag_idx_if idx_bus (); // carrier to the index scaler

    // index scaling lives in its own unit
    eag_index_scaler u_scaler (
        .idx (idx_bus.unit)
    );

    // field decode shared by every mode
    always_comb begin
        data_reg_sel = req_reg_num;
        addr_reg_sel = req_reg_num;
        index_reg_sel = req_index_sel;
        is_pc = (req_mode == EAG_M_PCDISP) || (req_mode == EAG_M_PCIDX8) ||
                (req_mode == EAG_M_PCIDXBD) || (req_mode == EAG_M_PCMIPOST) ||
                (req_mode == EAG_M_PCMIPRE);
        // pc replaces the address register as base
        base_val = is_pc ? req_pc : addr_regs[addr_reg_sel];
        base_disp = eag_sext(req_base_disp, req_base_disp_width);
        outer_disp = eag_sext(req_outer_disp, req_outer_disp_width);
        size_bytes = eag_size_bytes(req_op_size);
    end

    // index selection and default format
    always_comb begin
        // any data or address register may be the index
        if (index_reg_sel[`EAG_IDX_AREG_BIT]) begin
            idx_bus.idx_raw = addr_regs[index_reg_sel[2:0]];
        end else begin
            idx_bus.idx_raw = data_regs[index_reg_sel[2:0]];
        end
        // omitted size and scale mean word times one
        if (req_index_fmt_given) begin
            idx_bus.idx_long = req_index_long;
            idx_bus.idx_scale = req_index_scale;
        end else begin
            idx_bus.idx_long = `EAG_IDX_LONG_DFLT;
            idx_bus.idx_scale = `EAG_SCALE_ONE;
        end
        // an absent index adds nothing to idx_term; the brief indexed forms add idx_scaled regardless
        idx_term = req_index_present ? idx_bus.idx_scaled : 32'h00000000;
    end

    // request handshake: one request at a time
    always_comb begin
        req_ready = (state == EAG_ST_IDLE);
        take = req_valid && req_ready;
        mem_req = (state == EAG_ST_FETCH);
    end

    // next values of the sequencer group
    always_comb begin
        next_state = state;
        next_ea_valid = 1'b0;
        next_ea_kind = ea_kind;
        next_ea_value = ea_value;
        next_ea_reg_num = ea_reg_num;
        next_wb_valid = 1'b0;
        next_wb_reg_num = wb_reg_num;
        next_wb_value = wb_value;
        next_mem_addr = mem_addr;
        next_post_add = post_add;
        unique case (state)
            // address of a newly taken request
            EAG_ST_IDLE: begin
                if (take) begin
                    next_state = EAG_ST_DONE;
                    next_ea_valid = 1'b1;
                    next_ea_kind = EAG_K_MEM;
                    next_ea_reg_num = `EAG_RST_REGNUM;
                    unique case (req_mode)
                        // register direct
                        EAG_M_DREG: begin
                            next_ea_kind = EAG_K_DREG;
                            next_ea_reg_num = data_reg_sel;
                            next_ea_value = data_regs[data_reg_sel];
                        end
                        EAG_M_AREG: begin
                            next_ea_kind = EAG_K_AREG;
                            next_ea_reg_num = addr_reg_sel;
                            next_ea_value = addr_regs[addr_reg_sel];
                        end
                        // register indirect variants
                        EAG_M_AIND: begin
                            next_ea_value = base_val;
                        end
                        EAG_M_APOSTINC: begin
                            next_ea_value = base_val;
                            next_wb_valid = 1'b1;
                            next_wb_reg_num = addr_reg_sel;
                            next_wb_value = base_val + size_bytes;
                        end
                        EAG_M_APREDEC: begin
                            // decremented value is the address used
                            next_ea_value = base_val - size_bytes;
                            next_wb_valid = 1'b1;
                            next_wb_reg_num = addr_reg_sel;
                            next_wb_value = base_val - size_bytes;
                        end
                        // 16-bit displacement
                        EAG_M_ADISP, EAG_M_PCDISP: begin
                            next_ea_value = base_val + eag_sext(req_base_disp, EAG_W_16);
                        end
                        // brief indexed form, 8-bit displacement
                        EAG_M_AIDX8, EAG_M_PCIDX8: begin
                            next_ea_value = base_val + eag_sext(req_base_disp, EAG_W_8) +
                                            idx_bus.idx_scaled;
                        end
                        // full indexed form with optional base displacement
                        EAG_M_AIDXBD, EAG_M_PCIDXBD: begin
                            next_ea_value = base_val + base_disp + idx_term;
                        end
                        // postindexed: index joins after the fetch
                        EAG_M_MIPOST, EAG_M_PCMIPOST: begin
                            next_state = EAG_ST_FETCH;
                            next_ea_valid = 1'b0;
                            next_mem_addr = base_val + base_disp;
                            next_post_add = idx_term + outer_disp;
                        end
                        // preindexed: index joins before the fetch
                        EAG_M_MIPRE, EAG_M_PCMIPRE: begin
                            next_state = EAG_ST_FETCH;
                            next_ea_valid = 1'b0;
                            next_mem_addr = base_val + base_disp + idx_term;
                            next_post_add = outer_disp;
                        end
                        // absolute short and long
                        EAG_M_ABSW: begin
                            next_ea_value = eag_sext(req_ext_data, EAG_W_16);
                        end
                        EAG_M_ABSL: begin
                            next_ea_value = req_ext_data;
                        end
                        // immediate operand, zero above its width
                        EAG_M_IMM: begin
                            next_ea_kind = EAG_K_IMM;
                            unique case (req_ext_width)
                                EAG_W_8: next_ea_value = {24'h000000, req_ext_data[7:0]};
                                EAG_W_16: next_ea_value = {16'h0000, req_ext_data[15:0]};
                                EAG_W_32: next_ea_value = req_ext_data;
                                EAG_W_NONE: next_ea_value = req_ext_data;
                            endcase
                        end
                        // undefined mode code: answer zero address
                        default: begin
                            next_ea_value = `EAG_RST_WORD;
                        end
                    endcase
                end
            end
            // wait for the long-word pointer
            EAG_ST_FETCH: begin
                if (mem_ack) begin
                    next_state = EAG_ST_DONE;
                    next_ea_valid = 1'b1;
                    next_ea_kind = EAG_K_MEM;
                    next_ea_value = mem_rdata + post_add;
                end
            end
            // answer presented, return to idle
            EAG_ST_DONE: begin
                next_state = EAG_ST_IDLE;
            end
            // illegal one-hot code: recover to idle
            default: begin
                next_state = EAG_ST_IDLE;
            end
        endcase
    end

    // registers of the sequencer group
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= EAG_ST_IDLE;
            ea_valid <= 1'b0;
            ea_kind <= EAG_K_MEM;
            ea_value <= `EAG_RST_WORD;
            ea_reg_num <= `EAG_RST_REGNUM;
            wb_valid <= 1'b0;
            wb_reg_num <= `EAG_RST_REGNUM;
            wb_value <= `EAG_RST_WORD;
            mem_addr <= `EAG_RST_WORD;
            post_add <= `EAG_RST_WORD;
        end else begin
            state <= next_state;
            ea_valid <= next_ea_valid;
            ea_kind <= next_ea_kind;
            ea_value <= next_ea_value;
            ea_reg_num <= next_ea_reg_num;
            wb_valid <= next_wb_valid;
            wb_reg_num <= next_wb_reg_num;
            wb_value <= next_wb_value;
            mem_addr <= next_mem_addr;
            post_add <= next_post_add;
        end
    end
endmodule // eag_top

`default_nettype wire

// File: testbench/eag_asserts.sv
// checker: answer timing, fetch handshake and address arithmetic
// assumes a bind onto eag_top; sees only its ports
`timescale 1ns/1ps
`default_nettype none

module eag_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire eag_pkg::eag_mode_t req_mode,
    input wire logic [2:0] req_reg_num,
    input wire eag_pkg::eag_size_t req_op_size,
    input wire logic [31:0] req_base_disp,
    input wire logic [31:0] req_pc,
    input wire logic [7:0][31:0] addr_regs,
    input wire logic ea_valid,
    input wire eag_pkg::eag_kind_t ea_kind,
    input wire logic [31:0] ea_value,
    input wire logic wb_valid,
    input wire logic [31:0] wb_value,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack
);
    import eag_pkg::*;

    logic take; // request taken at this edge
    logic mi; // memory indirect mode on the inputs
    logic tk; // cycle after a take
    eag_mode_t tk_mode; // mode of that take
    logic [31:0] tk_ar, tk_pc, tk_d16, tk_step; // operands of that take
    assign take = req_valid && req_ready;
    assign mi = req_mode inside {EAG_M_MIPOST, EAG_M_MIPRE, EAG_M_PCMIPOST, EAG_M_PCMIPRE};

    // capture operands at the take
    always_ff @(posedge ref_clk) begin
        tk <= take && !rst;
        tk_mode <= req_mode;
        tk_ar <= addr_regs[req_reg_num];
        tk_pc <= req_pc;
        tk_d16 <= {{16{req_base_disp[15]}}, req_base_disp[15:0]};
        tk_step <= 32'h1 << req_op_size;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_take_mi;
        take && mi;
    endsequence
    sequence s_fetch_end;
        mem_req && mem_ack;
    endsequence
    sequence s_step;
        tk && (tk_mode inside {EAG_M_APREDEC, EAG_M_APOSTINC});
    endsequence

    property p_direct; take && !mi |=> ea_valid && !mem_req; endproperty
    a_direct: assert property (p_direct) else $error("direct answer late");
    property p_fetch; s_take_mi |=> mem_req && !ea_valid; endproperty
    a_fetch: assert property (p_fetch) else $error("no pointer fetch");
    property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("fetch not held");
    property p_end; s_fetch_end |=> ea_valid && !mem_req && ea_kind == EAG_K_MEM; endproperty
    a_end: assert property (p_end) else $error("fetch answer wrong");
    property p_predec; s_step ##0 tk_mode == EAG_M_APREDEC |-> wb_valid
        && ea_value == tk_ar - tk_step && wb_value == ea_value; endproperty
    a_predec: assert property (p_predec) else $error("predecrement wrong");
    property p_postinc; s_step ##0 tk_mode == EAG_M_APOSTINC |-> wb_valid
        && ea_value == tk_ar && wb_value == tk_ar + tk_step; endproperty
    a_postinc: assert property (p_postinc) else $error("postincrement wrong");
    property p_adisp; tk && tk_mode == EAG_M_ADISP |-> ea_value == tk_ar + tk_d16; endproperty
    a_adisp: assert property (p_adisp) else $error("d16 sum wrong");
    property p_pcdisp; tk && tk_mode == EAG_M_PCDISP |-> ea_value == tk_pc + tk_d16; endproperty
    a_pcdisp: assert property (p_pcdisp) else $error("pc d16 sum wrong");
    property p_nowb; wb_valid |-> s_step; endproperty
    a_nowb: assert property (p_nowb) else $error("stray writeback");
endmodule // eag_checker

`default_nettype wire

// File: testbench/eag_bus_model.sv
// bus controller model: answers pointer reads after a set delay
// assumes one clock with the generator; data valid only with ack
`timescale 1ns/1ps
`default_nettype none

module eag_bus_model #(
    parameter logic [31:0] KEY = 32'h5A3C96E1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] delay,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [3:0] cnt; // cycles waited so far

    // ack pulse after delay cycles; data toggles outside the ack
    always_ff @(posedge ref_clk) begin
        mem_rdata <= rst ? KEY : ~mem_rdata;
        if (rst || mem_ack || !mem_req) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
        end else if (cnt == delay) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem_addr ^ KEY;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule // eag_bus_model

`default_nettype wire

// File: testbench/tb_top.sv
// bench: every mode with random operands against a reference model
// assumes the design package compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import eag_pkg::*;

    localparam logic [31:0] KEY = 32'h5A3C96E1; // pointer data scramble
    logic ref_clk, rst, req_valid, req_ready, req_index_present, req_index_fmt_given;
    logic req_index_long, ea_valid, wb_valid, mem_req, mem_ack;
    eag_mode_t req_mode;
    eag_size_t req_op_size;
    eag_width_t req_base_disp_width, req_outer_disp_width, req_ext_width;
    eag_kind_t ea_kind, e_kind;
    logic [1:0] req_index_scale;
    logic [2:0] req_reg_num, ea_reg_num, wb_reg_num, e_rn;
    logic [3:0] req_index_sel, bus_delay;
    logic [31:0] req_base_disp, req_outer_disp, req_ext_data, req_pc, ea_value, wb_value;
    logic [31:0] mem_addr, mem_rdata, e_val, e_wbv, e_addr;
    logic [7:0][31:0] data_regs, addr_regs;
    logic e_wb, e_mi; // expected writeback, expected fetch
    integer seed = 32'h96384F8C;
    int n_errors = 0;
    int cmp_count = 0;

    eag_top dut (.ref_clk, .rst, .req_valid, .req_ready, .req_mode, .req_reg_num, .req_op_size,
        .req_index_present, .req_index_sel, .req_index_fmt_given, .req_index_long,
        .req_index_scale, .req_base_disp, .req_base_disp_width, .req_outer_disp,
        .req_outer_disp_width, .req_ext_data, .req_ext_width, .req_pc, .data_regs,
        .addr_regs, .ea_valid, .ea_kind, .ea_value, .ea_reg_num, .wb_valid, .wb_reg_num,
        .wb_value, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
    eag_bus_model #(.KEY(KEY)) u_bus (.ref_clk, .rst, .mem_req, .mem_addr,
        .delay(bus_delay), .mem_ack, .mem_rdata);

    // free-running core clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] sx(input logic [31:0] v, input int w);
        if (w == 1) return {{24{v[7]}}, v[7:0]};
        if (w == 2) return {{16{v[15]}}, v[15:0]};
        return (w == 3) ? v : 32'h0;
    endfunction

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic end_sim;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // reference model of the answer to the pending request
    task automatic predict;
        logic [31:0] base, ix, bd, od, pix;
        int m;
        m = int'(req_mode);
        base = (m >= 10 && m <= 14) ? req_pc : addr_regs[req_reg_num];
        ix = req_index_sel[3] ? addr_regs[req_index_sel[2:0]] : data_regs[req_index_sel[2:0]];
        if (!req_index_fmt_given || !req_index_long) ix = sx(ix, 2);
        if (req_index_fmt_given) ix = ix << req_index_scale;
        pix = req_index_present ? ix : 32'h0;
        bd = sx(req_base_disp, int'(req_base_disp_width));
        od = sx(req_outer_disp, int'(req_outer_disp_width));
        e_kind = EAG_K_MEM;
        e_rn = 3'h0;
        e_wb = 1'b0;
        e_mi = 1'b0;
        e_val = base;
        case (m)
            0: begin e_kind = EAG_K_DREG; e_rn = req_reg_num; e_val = data_regs[req_reg_num]; end
            1: begin e_kind = EAG_K_AREG; e_rn = req_reg_num; end
            3: begin e_wb = 1'b1; e_wbv = base + (32'h1 << req_op_size); end
            4: begin e_val = base - (32'h1 << req_op_size); e_wb = 1'b1; e_wbv = e_val; end
            5, 10: e_val = base + sx(req_base_disp, 2);
            6, 11: e_val = base + sx(req_base_disp, 1) + ix;
            7, 12: e_val = base + bd + pix;
            8, 13: begin e_mi = 1'b1; e_addr = base + bd; e_val = (e_addr ^ KEY) + pix + od; end
            9, 14: begin e_mi = 1'b1; e_addr = base + bd + pix; e_val = (e_addr ^ KEY) + od; end
            15: e_val = sx(req_ext_data, 2);
            16: e_val = req_ext_data;
            17: begin e_kind = EAG_K_IMM; e_val = (req_ext_width == EAG_W_8) ? req_ext_data & 32'hFF
                : (req_ext_width == EAG_W_16) ? req_ext_data & 32'hFFFF : req_ext_data; end
            default: e_val = (m == 2) ? base : 32'h0;
        endcase
    endtask

    // one request of the given mode with random operands
    task automatic run(input int m);
        int n;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_mode <= eag_mode_t'(5'(m));
        req_reg_num <= 3'($random(seed));
        req_op_size <= eag_size_t'(2'({$random(seed)} % 3));
        {req_index_present, req_index_fmt_given, req_index_long} <= 3'($random(seed));
        {req_index_sel, req_index_scale} <= 6'($random(seed));
        req_base_disp <= $random(seed);
        req_outer_disp <= $random(seed);
        req_ext_data <= $random(seed);
        req_pc <= $random(seed);
        req_base_disp_width <= eag_width_t'(2'($random(seed)));
        req_outer_disp_width <= eag_width_t'(2'($random(seed)));
        req_ext_width <= eag_width_t'(2'($random(seed)));
        bus_delay <= 4'({$random(seed)} % 6);
        for (int i = 0; i < 8; i++) begin
            data_regs[i] <= $random(seed);
            addr_regs[i] <= $random(seed);
        end
        @(negedge ref_clk);
        predict;
        chk_word("req_ready", 32'h1, 32'(req_ready));
        @(posedge ref_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (n == 1) chk_word("mem_req", 32'(e_mi), 32'(mem_req));
            if (n == 1 && e_mi) chk_word("mem_addr", e_addr, mem_addr);
        end while (ea_valid !== 1'b1 && n < 40);
        if (ea_valid !== 1'b1) begin
            n_errors++;
            end_sim;
        end
        chk_word("ea_value", e_val, ea_value);
        chk_word("ea_kind", 32'(e_kind), 32'(ea_kind));
        chk_word("ea_reg_num", 32'(e_rn), 32'(ea_reg_num));
        chk_word("wb_valid", 32'(e_wb), 32'(wb_valid));
        if (e_wb) chk_word("wb_value", e_wbv, wb_value);
        if (e_wb) chk_word("wb_reg_num", 32'(req_reg_num), 32'(wb_reg_num));
        chk_word("ready_busy", 32'h0, 32'(req_ready));
    endtask

    // reset, then all modes six times with a reset after each pass
    initial begin
        rst = 1'b1;
        {req_valid, req_index_present, req_index_fmt_given, req_index_long} = 4'h0;
        {req_reg_num, req_index_sel, req_index_scale, bus_delay} = '0;
        {req_base_disp, req_outer_disp, req_ext_data, req_pc, data_regs, addr_regs} = '0;
        req_mode = EAG_M_DREG;
        req_op_size = EAG_S_BYTE;
        req_base_disp_width = EAG_W_NONE;
        req_outer_disp_width = EAG_W_NONE;
        req_ext_width = EAG_W_NONE;
        repeat (4) @(posedge ref_clk);
        for (int p = 0; p < 6; p++) begin
            rst <= 1'b0;
            @(negedge ref_clk);
            chk_word("idle", 32'h1, 32'({ea_valid, wb_valid, mem_req, req_ready}));
            for (int m = 0; m < 19; m++) run(m);
            @(posedge ref_clk);
            rst <= 1'b1;
            @(posedge ref_clk);
        end
        end_sim;
    end
endmodule // tb_top

bind eag_top eag_checker u_chk (.ref_clk, .rst, .req_valid, .req_ready, .req_mode,
    .req_reg_num, .req_op_size, .req_base_disp, .req_pc, .addr_regs, .ea_valid, .ea_kind,
    .ea_value, .wb_valid, .wb_value, .mem_req, .mem_addr, .mem_ack);

`default_nettype wire
